// ### core/fle_regs.svh
// Register offsets, field positions, reset values and cycle counts.
`ifndef FLE_REGS_SVH
`define FLE_REGS_SVH
`define FLE_CMD_OFS     8'h00
`define FLE_STAT_OFS    8'h04
`define FLE_SP_OFS      8'h08
`define FLE_GPR_OFS     8'h80
`define FLE_OP_LSB      0
`define FLE_RD_LSB      5
`define FLE_RR_LSB      10
`define FLE_K_LSB       16
`define FLE_STAT_BUSY   8
`define FLE_STAT_ILL    9
`define FLE_SB_RST      8'h00
`define FLE_SP_RST      16'h00ff
`define FLE_CYC_ONE     2'h1
`define FLE_CYC_TWO     2'h2
`define FLE_CYC_THREE   2'h3
`define FLE_PTR_X       2'h0
`define FLE_PTR_INV     2'h3
`endif

// ### core/fle_pkg.sv
// Types shared by the flag and load/store execution unit.
package fle_pkg;
    typedef enum logic [4:0] {
        OP_FLAG_SET, OP_FLAG_CLR, OP_MOV, OP_PAIR_COPY, OP_IMM_LOAD,
        OP_LD, OP_LD_INC, OP_LD_DEC, OP_OFFSET_LOAD, OP_ABSOLUTE_LOAD,
        OP_ST, OP_ST_INC, OP_ST_DEC, OP_OFFSET_STORE, OP_ABSOLUTE_STORE,
        OP_CODE_READ_R0, OP_CODE_READ, OP_CODE_READ_INC, OP_CODE_WRITE,
        OP_PORT_IN, OP_PORT_OUT, OP_PUSH
    } fle_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PMW} fle_state_t;
endpackage

// ### core/fle_exec.sv
// Execution unit for flag set/clear and data transfer operations.
//
// Chosen here: the address map and the Avalon-MM slave port.
`include "fle_regs.svh"
// Functional notes
// - Each flag set or clear forces only its named status bit, one cycle.
// - Signed flag set or clear writes only the signed bit, one cycle.
// - Overflow set drives only the overflow bit to one, one cycle.
// - Move copies a register, pair copy copies a pair, one cycle each.
// - Post-increment load reads at pointer, then adds one, two cycles.
// - Pre-decrement load subtracts one, then reads there, two cycles.
// - Offset load via Y or Z reads pointer plus offset, pointer kept.
// - Post-increment store writes at pointer, then adds one, two cycles.
// - Pre-decrement store subtracts one, then writes there, two cycles.
// - Offset store via Y or Z writes pointer plus offset, two cycles.
// - Absolute load reads the address carried in the command, two cycles.
// - Absolute store writes the address carried in the command, two cycles.
// - Code memory read loads byte at Z, optional Z increment, three cycles.
// - Push writes the register onto the stack in two cycles.
module fle_exec
    import fle_pkg::*;
(
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    input  wire logic [7:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    output logic      [15:0] DM_ADDR_O,
    output logic             DM_RE_O,
    output logic             DM_WE_O,
    output logic      [7:0]  DM_WDATA_O,
    input  wire logic [7:0]  DM_RDATA_I,
    output logic      [14:0] PM_ADDR_O,
    output logic             PM_RE_O,
    output logic             PM_WE_O,
    output logic      [15:0] PM_WDATA_O,
    input  wire logic [15:0] PM_RDATA_I,
    input  wire logic        PM_DONE_I,
    output logic      [5:0]  IO_ADDR_O,
    output logic             IO_RE_O,
    output logic             IO_WE_O,
    output logic      [7:0]  IO_WDATA_O,
    input  wire logic [7:0]  IO_RDATA_I,
    output logic      [7:0]  STATUS_BITS_O,
    output logic             BUSY_O
);
    fle_state_t  state_q;
    logic [31:0] cmd_q;
    logic [1:0]  cnt_q;
    logic [7:0]  status_bits_q;
    logic        illegal_q;
    logic [15:0] sp_q;
    logic        rd_ack_q;
    logic [7:0]  gpr_q [32];
    logic        busy;
    logic        accept;
    logic        exec_done;
    logic        cmd_ok;
    fle_op_t     cmd_op;
    fle_op_t     op;
    logic [4:0]  cmd_rd;
    logic [15:0] cmd_k;
    logic [4:0]  cmd_pi;
    logic [15:0] cmd_ptr;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [15:0] k;
    logic [4:0]  pi;
    logic [15:0] ptr_val;
    logic [15:0] z_val;
    logic [7:0]  rr_val;
    default clocking core_cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I || !CE_I);

    // Low register index of the pointer pair X, Y or Z.
    function automatic logic [4:0] pair_idx(input logic [1:0] sel);
        return 5'h1a + {2'h0, sel, 1'b0};
    endfunction

    function automatic logic [1:0] op_cycles(input fle_op_t o);
        unique case (o)
            OP_FLAG_SET, OP_FLAG_CLR, OP_MOV, OP_PAIR_COPY, OP_IMM_LOAD,
            OP_PORT_IN, OP_PORT_OUT, OP_CODE_WRITE: return `FLE_CYC_ONE;
            OP_CODE_READ_R0, OP_CODE_READ, OP_CODE_READ_INC:
                return `FLE_CYC_THREE;
            default: return `FLE_CYC_TWO;
        endcase
    endfunction

    // Offset forms exist only for Y and Z; the fourth pointer code is void.
    function automatic logic op_legal(input logic [4:0] code,
                                      input logic [1:0] sel);
        logic ptr_op;
        logic ofs_op;
        ptr_op = code >= 5'(OP_LD) && code <= 5'(OP_ST_DEC)
                 && code != 5'(OP_ABSOLUTE_LOAD);
        ofs_op = code == 5'(OP_OFFSET_LOAD) || code == 5'(OP_OFFSET_STORE);
        return code <= 5'(OP_PUSH) && !(ptr_op && sel == `FLE_PTR_INV)
               && !(ofs_op && sel == `FLE_PTR_X)
               && !(ofs_op && sel == `FLE_PTR_INV);
    endfunction

    assign busy      = state_q != ST_IDLE;
    assign cmd_op    = fle_op_t'(AVS_WRITEDATA_I[`FLE_OP_LSB +: 5]);
    assign cmd_rd    = AVS_WRITEDATA_I[`FLE_RD_LSB +: 5];
    assign cmd_k     = AVS_WRITEDATA_I[`FLE_K_LSB +: 16];
    assign cmd_pi    = pair_idx(AVS_WRITEDATA_I[`FLE_RR_LSB +: 2]);
    assign cmd_ptr   = {gpr_q[cmd_pi | 5'h01], gpr_q[cmd_pi]};
    assign cmd_ok    = op_legal(AVS_WRITEDATA_I[`FLE_OP_LSB +: 5],
                                AVS_WRITEDATA_I[`FLE_RR_LSB +: 2]);
    assign accept    = CE_I && AVS_WRITE_I && !busy
                       && AVS_ADDRESS_I == `FLE_CMD_OFS;
    assign op        = fle_op_t'(cmd_q[`FLE_OP_LSB +: 5]);
    assign rd        = cmd_q[`FLE_RD_LSB +: 5];
    assign rr        = cmd_q[`FLE_RR_LSB +: 5];
    assign k         = cmd_q[`FLE_K_LSB +: 16];
    assign pi        = pair_idx(rr[1:0]);
    assign ptr_val   = {gpr_q[pi | 5'h01], gpr_q[pi]};
    assign z_val     = {gpr_q[5'h1f], gpr_q[5'h1e]};
    assign rr_val    = gpr_q[rr];
    assign exec_done = CE_I && state_q == ST_EXEC && cnt_q == 2'h0;
    assign BUSY_O        = busy;
    assign STATUS_BITS_O = status_bits_q;

    // A write must wait while an operation runs so no command is lost.
    assign AVS_WAITREQUEST_O = (AVS_WRITE_I && (busy || !CE_I))
                               || (AVS_READ_I && !rd_ack_q);

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cnt_q   <= 2'h0;
            cmd_q   <= 32'h0000_0000;
        end else if (CE_I) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (accept && cmd_ok) begin
                        state_q <= ST_EXEC;
                        cmd_q   <= AVS_WRITEDATA_I;
                        cnt_q   <= op_cycles(cmd_op) - 2'h1;
                    end
                end
                ST_EXEC: begin
                    if (cnt_q != 2'h0) begin
                        cnt_q <= cnt_q - 2'h1;
                    end else if (op == OP_CODE_WRITE && !PM_DONE_I) begin
                        state_q <= ST_PMW;
                    end else begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_PMW: begin
                    if (PM_DONE_I) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Memory and port strobes are issued at acceptance for one busy cycle.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            {DM_ADDR_O, DM_RE_O, DM_WE_O, DM_WDATA_O} <= 26'h0;
            {PM_ADDR_O, PM_RE_O, PM_WE_O, PM_WDATA_O} <= 33'h0;
            {IO_ADDR_O, IO_RE_O, IO_WE_O, IO_WDATA_O} <= 16'h0;
        end else if (CE_I) begin
            {DM_RE_O, DM_WE_O, PM_RE_O, PM_WE_O, IO_RE_O, IO_WE_O} <= 6'h00;
            if (accept && cmd_ok) begin
                DM_WDATA_O <= gpr_q[cmd_rd];
                IO_WDATA_O <= gpr_q[cmd_rd];
                IO_ADDR_O  <= cmd_k[5:0];
                PM_ADDR_O  <= z_val[15:1];
                PM_WDATA_O <= {gpr_q[5'h01], gpr_q[5'h00]};
                unique case (cmd_op)
                    OP_LD, OP_LD_INC, OP_ST, OP_ST_INC: begin
                        DM_ADDR_O <= cmd_ptr;
                    end
                    OP_LD_DEC, OP_ST_DEC: begin
                        DM_ADDR_O <= cmd_ptr - 16'h0001;
                    end
                    OP_OFFSET_LOAD, OP_OFFSET_STORE: begin
                        DM_ADDR_O <= cmd_ptr + {10'h000, cmd_k[5:0]};
                    end
                    OP_ABSOLUTE_LOAD, OP_ABSOLUTE_STORE: begin
                        DM_ADDR_O <= cmd_k;
                    end
                    OP_PUSH: DM_ADDR_O <= sp_q;
                    default: DM_ADDR_O <= DM_ADDR_O;
                endcase
                DM_RE_O <= cmd_op inside {OP_LD, OP_LD_INC, OP_LD_DEC,
                                          OP_OFFSET_LOAD, OP_ABSOLUTE_LOAD};
                DM_WE_O <= cmd_op inside {OP_ST, OP_ST_INC, OP_ST_DEC,
                                          OP_OFFSET_STORE, OP_ABSOLUTE_STORE,
                                          OP_PUSH};
                PM_RE_O <= cmd_op inside {OP_CODE_READ_R0, OP_CODE_READ,
                                          OP_CODE_READ_INC};
                PM_WE_O <= cmd_op == OP_CODE_WRITE;
                IO_RE_O <= cmd_op == OP_PORT_IN;
                IO_WE_O <= cmd_op == OP_PORT_OUT;
            end
        end
    end

    // Completion writes happen on the last busy cycle; software writes
    // only reach the file while idle, so the two never meet.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            for (int i = 0; i < 32; i++) begin
                gpr_q[i] <= 8'h00;
            end
        end else if (CE_I && !busy && AVS_WRITE_I
                     && AVS_ADDRESS_I[7] == 1'b1) begin
            gpr_q[AVS_ADDRESS_I[6:2]] <= AVS_WRITEDATA_I[7:0];
        end else if (exec_done) begin
            unique case (op)
                OP_MOV: gpr_q[rd] <= rr_val;
                OP_PAIR_COPY: begin
                    gpr_q[{rd[4:1], 1'b0}] <= gpr_q[{rr[4:1], 1'b0}];
                    gpr_q[{rd[4:1], 1'b1}] <= gpr_q[{rr[4:1], 1'b1}];
                end
                OP_IMM_LOAD: gpr_q[rd] <= k[7:0];
                OP_PORT_IN: gpr_q[rd] <= IO_RDATA_I;
                OP_LD, OP_OFFSET_LOAD, OP_ABSOLUTE_LOAD: begin
                    gpr_q[rd] <= DM_RDATA_I;
                end
                OP_LD_INC, OP_LD_DEC: begin
                    gpr_q[rd] <= DM_RDATA_I;
                    {gpr_q[pi | 5'h01], gpr_q[pi]} <= (op == OP_LD_INC)
                        ? ptr_val + 16'h0001 : ptr_val - 16'h0001;
                end
                OP_ST_INC, OP_ST_DEC: begin
                    {gpr_q[pi | 5'h01], gpr_q[pi]} <= (op == OP_ST_INC)
                        ? ptr_val + 16'h0001 : ptr_val - 16'h0001;
                end
                OP_CODE_READ_R0: begin
                    gpr_q[5'h00] <= z_val[0] ? PM_RDATA_I[15:8]
                                             : PM_RDATA_I[7:0];
                end
                OP_CODE_READ, OP_CODE_READ_INC: begin
                    gpr_q[rd] <= z_val[0] ? PM_RDATA_I[15:8]
                                          : PM_RDATA_I[7:0];
                    if (op == OP_CODE_READ_INC) begin
                        {gpr_q[5'h1f], gpr_q[5'h1e]} <= z_val + 16'h0001;
                    end
                end
                default: gpr_q[rd] <= gpr_q[rd];
            endcase
        end
    end

    // Status bits: flag operations touch one bit only.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            status_bits_q <= `FLE_SB_RST;
        end else if (CE_I && !busy && AVS_WRITE_I
                     && AVS_ADDRESS_I == `FLE_STAT_OFS) begin
            status_bits_q <= AVS_WRITEDATA_I[7:0];
        end else if (exec_done && op == OP_FLAG_SET) begin
            status_bits_q[rr[2:0]] <= 1'b1;
        end else if (exec_done && op == OP_FLAG_CLR) begin
            status_bits_q[rr[2:0]] <= 1'b0;
        end
    end

    // A refused command raises the sticky flag; a new refusal wins over
    // the clear written in the same cycle.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            illegal_q <= 1'b0;
        end else if (CE_I) begin
            if (accept && !cmd_ok) begin
                illegal_q <= 1'b1;
            end else if (AVS_WRITE_I && !busy
                         && AVS_ADDRESS_I == `FLE_STAT_OFS
                         && AVS_WRITEDATA_I[`FLE_STAT_ILL]) begin
                illegal_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            sp_q <= `FLE_SP_RST;
        end else if (CE_I && !busy && AVS_WRITE_I
                     && AVS_ADDRESS_I == `FLE_SP_OFS) begin
            sp_q <= AVS_WRITEDATA_I[15:0];
        end else if (exec_done && op == OP_PUSH) begin
            sp_q <= sp_q - 16'h0001;
        end
    end

    // Reads take one wait cycle so that read data come from a register.
    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            rd_ack_q       <= 1'b0;
            AVS_READDATA_O <= 32'h0000_0000;
        end else if (CE_I) begin
            rd_ack_q <= AVS_READ_I && !rd_ack_q;
            if (AVS_READ_I && !rd_ack_q) begin
                if (AVS_ADDRESS_I[7]) begin
                    AVS_READDATA_O <= {24'h000000, gpr_q[AVS_ADDRESS_I[6:2]]};
                end else if (AVS_ADDRESS_I == `FLE_CMD_OFS) begin
                    AVS_READDATA_O <= cmd_q;
                end else if (AVS_ADDRESS_I == `FLE_STAT_OFS) begin
                    AVS_READDATA_O <= {22'h0, illegal_q, busy,
                                       status_bits_q};
                end else if (AVS_ADDRESS_I == `FLE_SP_OFS) begin
                    AVS_READDATA_O <= {16'h0000, sp_q};
                end else begin
                    AVS_READDATA_O <= 32'h0000_0000;
                end
            end
        end
    end

    sequence cmd_of(fle_op_t o);
        accept && cmd_ok && cmd_op == o;
    endsequence

    sequence code_read_issue;
        PM_RE_O && PM_ADDR_O == $past(z_val[15:1]);
    endsequence

    flag_set_bit_a: assert property (exec_done && op == OP_FLAG_SET
        |=> status_bits_q
            == ($past(status_bits_q) | (8'h01 << $past(rr[2:0]))))
        else $error("flag set changed the wrong bits");
    flag_clr_bit_a: assert property (exec_done && op == OP_FLAG_CLR
        |=> status_bits_q
            == ($past(status_bits_q) & ~(8'h01 << $past(rr[2:0]))))
        else $error("flag clear changed the wrong bits");
    flag_one_cycle_a: assert property (cmd_of(OP_FLAG_SET)
        |=> exec_done ##1 !busy)
        else $error("flag set did not finish in one cycle");
    mov_copy_a: assert property (exec_done && op == OP_MOV
        |=> gpr_q[$past(rd)] == $past(rr_val))
        else $error("move result wrong");
    ld_inc_ptr_a: assert property (cmd_of(OP_LD_INC) ##3 1'b1
        |-> ptr_val == $past(ptr_val) + 16'h0001 && !busy)
        else $error("post-increment load pointer or timing wrong");
    ld_dec_addr_a: assert property (cmd_of(OP_LD_DEC)
        |=> DM_RE_O && DM_ADDR_O == $past(cmd_ptr) - 16'h0001 ##1 exec_done)
        else $error("pre-decrement load address wrong");
    offset_keep_a: assert property (exec_done && (op == OP_OFFSET_LOAD
        || op == OP_OFFSET_STORE) |=> ptr_val == $past(ptr_val))
        else $error("offset access moved the pointer");
    st_two_cycle_a: assert property (cmd_of(OP_ABSOLUTE_STORE)
        |=> DM_WE_O && DM_ADDR_O == $past(cmd_k) ##1 exec_done && !DM_WE_O)
        else $error("absolute store strobe or timing wrong");
    code_read_three_a: assert property (cmd_of(OP_CODE_READ)
        |=> code_read_issue ##2 exec_done)
        else $error("code memory read not three cycles");
    push_stack_a: assert property (cmd_of(OP_PUSH)
        |=> DM_WE_O && DM_ADDR_O == $past(sp_q)
        ##2 sp_q == $past(sp_q, 3) - 16'h0001)
        else $error("push address or stack pointer wrong");
    code_write_wait_a: assert property (state_q == ST_PMW
        |=> busy != $past(PM_DONE_I))
        else $error("code write did not follow done");
endmodule // fle_exec

// ### bench/tb_flag_and_load_store_exec.sv
// Self-checking testbench for the flag and load/store execution unit.
module tb_flag_and_load_store_exec
    import fle_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, ce, av_rd, av_wr, av_wait, dm_re, dm_we;
    logic        pm_re, pm_we, pm_done, io_re, io_we, busy;
    logic [7:0]  av_addr, dm_wdata, dm_rdata, io_wdata, io_rdata, status;
    logic [7:0]  cyc, sb, v;
    logic [31:0] av_wdata, av_rdata;
    logic [15:0] dm_addr, pm_wdata, pm_rdata, ptr, a, np;
    logic [14:0] pm_addr;
    logic [5:0]  io_addr, q;
    logic [1:0]  pm_cnt, pm_dly;
    logic [7:0]  dmem [256];
    logic [7:0]  em [256];
    logic [31:0] rq [$];
    logic [31:0] wq [$];
    int          n_mismatch, check_count, seed;

    fle_exec dut (
        .CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .AVS_ADDRESS_I(av_addr),
        .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wdata),
        .AVS_READDATA_O(av_rdata), .AVS_WAITREQUEST_O(av_wait),
        .DM_ADDR_O(dm_addr), .DM_RE_O(dm_re), .DM_WE_O(dm_we),
        .DM_WDATA_O(dm_wdata), .DM_RDATA_I(dm_rdata), .PM_ADDR_O(pm_addr),
        .PM_RE_O(pm_re), .PM_WE_O(pm_we), .PM_WDATA_O(pm_wdata),
        .PM_RDATA_I(pm_rdata), .PM_DONE_I(pm_done), .IO_ADDR_O(io_addr),
        .IO_RE_O(io_re), .IO_WE_O(io_we), .IO_WDATA_O(io_wdata),
        .IO_RDATA_I(io_rdata), .STATUS_BITS_O(status), .BUSY_O(busy)
    );

    function automatic logic [7:0] ga(input int n);
        return 8'h80 + 8'(4 * n);
    endfunction
    function automatic logic [15:0] pw(input logic [14:0] w);
        return {w[7:0] ^ 8'hc3, w[7:0]};
    endfunction

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Idle lines show a changing pattern so a stale value cannot match; code read data hold while busy.
    assign io_rdata = io_re ? {2'b00, io_addr} ^ 8'h5a : cyc;
    always @(posedge clk) begin
        cyc <= cyc + 8'h01;
        dm_rdata <= dm_re ? dmem[dm_addr[7:0]] : cyc;
        if (dm_we)
            dmem[dm_addr[7:0]] <= dm_wdata;
        pm_rdata <= pm_re ? pw(pm_addr) : (busy ? pm_rdata : {cyc, ~cyc});
        pm_cnt <= pm_we ? pm_dly : pm_cnt - 2'(pm_cnt != 2'h0);
        pm_done <= pm_we ? (pm_dly == 2'h0) : (pm_cnt == 2'h1);
        if (av_rd && !av_wait)
            cmp(av_rdata, rq.size() != 0 ? rq.pop_front() : 32'hx);
        if (dm_we)
            cmp({8'h01, dm_addr, dm_wdata}, wq.size() ? wq.pop_front() : 'x);
        if (io_we)
            cmp({8'h02, 10'h0, io_addr, io_wdata},
                wq.size() ? wq.pop_front() : 'x);
        if (pm_we)
            cmp({1'b1, pm_addr, pm_wdata}, wq.size() ? wq.pop_front() : 'x);
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // The request is held until the edge that samples waitrequest low.
    task automatic bus(input logic [7:0] ad, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        av_addr <= ad;
        av_wr <= w;
        av_rd <= ~w;
        av_wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 200);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        if (av_wait !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        rq.push_back(e);
        bus(ad, 1'b0, 32'h0);
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(ad, 1'b1, d);
        @(posedge clk);
    endtask
    // Counts the cycles with busy high after the command is taken.
    task automatic cmd(input logic [4:0] o, input int d, input int r,
                       input logic [15:0] k, input int nc);
        int n;
        n = 0;
        bus(8'h00, 1'b1, {k, 1'b0, 5'(r), 5'(d), o});
        do begin
            @(posedge clk);
            n++;
        end while (busy === 1'b1 && n < 300);
        if (busy !== 1'b0) begin
            n_mismatch++;
            complete_run();
        end
        cmp(32'(n - 1), 32'(nc));
    endtask

    initial begin
        seed = 32081;
        n_mismatch = 0;
        check_count = 0;
        {rst, ce, av_rd, av_wr, av_addr, av_wdata} = {2'b11, 42'h0};
        {cyc, pm_cnt, pm_dly, pm_done, dm_rdata, pm_rdata} = 37'h0;
        for (int i = 0; i < 256; i++) begin
            dmem[i] = 8'(i) ^ 8'h3c;
            em[i] = dmem[i];
        end
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(8'h08, 32'h0000_00ff);
        rd(8'h04, 32'h0);
        rd(ga(31), 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd(8'h40, 32'h0);
        $display("test reset done");
        sb = 8'h00;
        for (int i = 0; i < 16; i++) begin
            cmd(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 0, i % 8, 16'h0, 1);
            sb[i % 8] = (i < 8);
            rd(8'h04, {24'h0, sb});
        end
        $display("test flags done");
        sb = 8'($random(seed));
        v = 8'($random(seed));
        wr(8'h04, {24'h0, sb});
        wr(ga(3), {24'h0, v});
        wr(ga(6), {24'h0, v ^ 8'h5a});
        wr(ga(7), {24'h0, ~v});
        cmd(OP_MOV, 5, 3, 16'h0, 1);
        rd(ga(5), {24'h0, v});
        cmd(OP_PAIR_COPY, 8, 6, 16'h0, 1);
        rd(ga(8), {24'h0, v ^ 8'h5a});
        rd(ga(9), {24'h0, ~v});
        cmd(OP_IMM_LOAD, 16, 0, {8'h0, ~v}, 1);
        rd(ga(16), {24'h0, ~v});
        $display("test moves done");
        for (int s = 0; s < 2; s++)
        for (int p = 0; p < 3; p++)
        for (int j = 0; j < 4; j++) begin
            if (p == 0 && j == 3)
                continue;
            ptr = 16'($random(seed));
            q = 6'($random(seed));
            v = 8'($random(seed));
            a = ptr + (j == 2 ? 16'hffff : (j == 3 ? {10'h0, q} : 16'h0));
            np = j == 1 ? ptr + 16'h1 : (j == 2 ? a : ptr);
            wr(ga(26 + 2 * p), {24'h0, ptr[7:0]});
            wr(ga(27 + 2 * p), {24'h0, ptr[15:8]});
            wr(ga(2), {24'h0, v});
            if (s == 1) begin
                wq.push_back({8'h01, a, v});
                em[a[7:0]] = v;
            end
            cmd(fle_op_t'((s ? OP_ST : OP_LD) + j), 2, p, {10'h0, q}, 2);
            rd(ga(2), {24'h0, s ? v : em[a[7:0]]});
            rd(ga(26 + 2 * p), {24'h0, np[7:0]});
            rd(ga(27 + 2 * p), {24'h0, np[15:8]});
        end
        a = 16'($random(seed));
        cmd(OP_ABSOLUTE_LOAD, 4, 0, a, 2);
        rd(ga(4), {24'h0, em[a[7:0]]});
        wq.push_back({8'h01, ~a, v});
        cmd(OP_ABSOLUTE_STORE, 2, 0, ~a, 2);
        $display("test data memory done");
        ptr = 16'($random(seed));
        wr(ga(30), {24'h0, ptr[7:0]});
        wr(ga(31), {24'h0, ptr[15:8]});
        for (int j = 0; j < 3; j++) begin
            a = pw(ptr[15:1]);
            cmd(fle_op_t'(OP_CODE_READ_R0 + j), 9, 2, 16'h0, 3);
            rd(ga(j == 0 ? 0 : 9), {24'h0, ptr[0] ? a[15:8] : a[7:0]});
            ptr = ptr + 16'(j == 2);
            rd(ga(30), {24'h0, ptr[7:0]});
        end
        wr(ga(0), {24'h0, v});
        wr(ga(1), {24'h0, ~v});
        pm_dly = 2'($random(seed));
        wq.push_back({1'b1, ptr[15:1], ~v, v});
        cmd(OP_CODE_WRITE, 0, 0, 16'h0, 2 + pm_dly);
        $display("test code memory done");
        q = 6'($random(seed));
        cmd(OP_PORT_IN, 10, 0, {10'h0, q}, 1);
        rd(ga(10), {24'h0, {2'b00, q} ^ 8'h5a});
        wq.push_back({8'h02, 10'h0, ~q, v});
        cmd(OP_PORT_OUT, 0, 0, {10'h0, ~q}, 1);
        wq.push_back({8'h01, 16'h00ff, v});
        cmd(OP_PUSH, 0, 0, 16'h0, 2);
        rd(8'h08, 32'h0000_00fe);
        $display("test ports and stack done");
        cmd(5'h16, 0, 0, 16'h0, 0);
        cmd(OP_OFFSET_LOAD, 2, 0, 16'h0, 0);
        rd(8'h04, {22'h0, 2'b10, sb});
        wr(8'h04, {22'h0, 2'b10, sb});
        rd(8'h04, {24'h0, sb});
        cmp(32'(wq.size() + rq.size()), 32'h0);
        $display("test refusals done");
        complete_run();
    end
endmodule // tb_flag_and_load_store_exec
